// [hw/sqseg_consts.svh]
`ifndef SQSEG_CONSTS_SVH
`define SQSEG_CONSTS_SVH
// Register indices as printed; byte address is four times the index
`define SQSEG_IDX_MODE 32'd9500
`define SQSEG_IDX_CAP 32'd349900
`define SQSEG_IDX_COUNT 32'd349910
`define SQSEG_IDX_SELECT 32'd349920
`define SQSEG_IDX_LENGTH 32'd349940
`define SQSEG_IDX_STATUS 32'd349950
`define SQSEG_IDX_START 32'd349951
// Mode code for sequence replay
`define SQSEG_SEQ_CODE 32'h00040000
// Reset values
`define SQSEG_MODE_RST 32'h00000000
`define SQSEG_COUNT_RST 32'h00000001
`define SQSEG_SELECT_RST 32'h00000000
`define SQSEG_LENGTH_RST 32'h00000000
// Segment length limits in samples
`define SQSEG_MIN_32 32'd32
`define SQSEG_MIN_48 32'd48
`define SQSEG_STEP_4 32'd4
`define SQSEG_STEP_8 32'd8
`define SQSEG_STEP_16 32'd16
// Status field positions
`define SQSEG_ST_ERR 0
`define SQSEG_ST_RUN 1
`define SQSEG_ST_CHAN 2
`define SQSEG_ST_WIPE 3
`endif

// [hw/sqseg_pkg.sv]
package sqseg_pkg;
  typedef enum logic [1:0] {
    SQSEG_IDLE = 2'b00,
    SQSEG_WIPE = 2'b01,
    SQSEG_RUN = 2'b11
  } sqseg_state_type;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sqseg_bus_type;
  typedef struct packed {
    logic [31:0] minimum;
    logic [31:0] step_mask;
    logic [5:0] div_shift;
    logic chan_ok;
  } sqseg_limit_type;
endpackage

// [hw/sqseg_len_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// Per-segment length store with registered read port
module sqseg_len_mem
#(
  parameter int DEPTH_LOG2 = 10
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Write port
  input wire logic wr_en,
  input wire logic [DEPTH_LOG2-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Clear request wipes every word, one per cycle
  input wire logic clr_en,
  input wire logic [DEPTH_LOG2-1:0] clr_addr,
  // Read port; a bypass word replaces the memory word for the other registers
  input wire logic [DEPTH_LOG2-1:0] rd_addr,
  input wire logic byp_en,
  input wire logic [31:0] byp_data,
  output logic [31:0] rd_data
);
  logic [31:0] mem [0:(1<<DEPTH_LOG2)-1];
  logic [31:0] rd_q;

  // Clear takes priority so a wipe is never undone by a stray write
  always_ff @(posedge mclk)
  begin
    if (clr_en)
    begin
      mem[clr_addr] <= 32'h00000000;
    end
    else if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read data; one stage serves every register so the read word leaves a flop
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_q <= 32'h00000000;
    end
    else if (byp_en)
    begin
      rd_q <= byp_data;
    end
    else
    begin
      rd_q <= mem[rd_addr];
    end
  end

  assign rd_data = rd_q;
endmodule
`default_nettype wire

// [hw/sqseg_top.sv]
// Operation
// - The sequence replay code in the mode register makes the card replay segmented memory.
// - The segment count sets equal memory segments and accepts only powers of two.
// - Writing a new segment count wipes all stored segment setup, which software then rewrites.
// - Reading the segment count returns the current division of memory.
// - The segment select holds the segment that later parameter writes and transfers address.
// - The segment length stores the valid sample count of the selected segment.
// - With 14-bit converters a length is at least 32 and a multiple of 8.
// - With 8-bit converters a length is at least 48 and a multiple of 16.
// - Digital cards refuse 1, 2 or 4 channels and use per-channel minimum and step limits.
// - The longest length is installed memory over the channel divider over the segment count.
// - Limits count samples and follow installed memory from 32 MSample to 4 GSample.
// - A read-only capability register reports the largest power-of-two segment count.
`timescale 1ns/1ps
`default_nettype none
`include "sqseg_consts.svh"
module sqseg_top
  import sqseg_pkg::*;
#(
  parameter int SEG_LOG2 = 10,
  parameter logic [32:0] MEM_SAMPLES = 33'h002000000,
  parameter logic IS_DIGITAL = 1'b0,
  parameter logic IS_8BIT = 1'b0
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Active channel count, 1..64
  input wire logic [6:0] active_channels,
  // Replay control towards the sequencer
  output logic replay_run,
  output logic seq_mode,
  output logic [31:0] segment_count_out,
  output logic cfg_error
);
  localparam logic [31:0] SEG_CAP = 32'(1) << SEG_LOG2;

  sqseg_bus_type bus;
  sqseg_limit_type lim;
  sqseg_state_type st_q, st_d;
  logic [31:0] mode_q, mode_d;
  logic [31:0] count_q, count_d;
  logic [31:0] sel_q, sel_d;
  logic [31:0] rdata_d;
  logic err_q, err_d;
  logic [SEG_LOG2-1:0] wipe_q, wipe_d;
  logic [SEG_LOG2-1:0] scan_q, scan_d;
  logic scan_bad_q, scan_bad_d;
  logic scan_done_q, scan_done_d;
  logic scan_pend_q, scan_pend_d;
  logic scan_last_q, scan_last_d;
  logic [31:0] mem_rdata;
  logic [SEG_LOG2-1:0] mem_raddr;
  logic len_wr;
  logic [32:0] max_len;
  logic count_ok;
  logic len_bad;
  logic [31:0] status_word;
  logic [5:0] count_log2;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Channel-dependent minimum, step and divider
  always_comb
  begin
    lim = '{minimum: `SQSEG_MIN_32, step_mask: `SQSEG_STEP_8 - 32'd1, div_shift: 6'd0,
            chan_ok: 1'b1};
    if (IS_DIGITAL)
    begin
      unique case (active_channels)
        7'd8: lim = '{minimum: `SQSEG_MIN_48, step_mask: `SQSEG_STEP_16 - 32'd1,
                      div_shift: 6'd0, chan_ok: 1'b1};
        7'd16: lim = '{minimum: `SQSEG_MIN_32, step_mask: `SQSEG_STEP_8 - 32'd1,
                       div_shift: 6'd1, chan_ok: 1'b1};
        7'd32: lim = '{minimum: `SQSEG_MIN_32, step_mask: `SQSEG_STEP_4 - 32'd1,
                       div_shift: 6'd2, chan_ok: 1'b1};
        7'd64: lim = '{minimum: `SQSEG_MIN_32, step_mask: `SQSEG_STEP_4 - 32'd1,
                       div_shift: 6'd3, chan_ok: 1'b1};
        default: lim.chan_ok = 1'b0;
      endcase
    end
    else
    begin
      if (IS_8BIT)
      begin
        lim.minimum = `SQSEG_MIN_48;
        lim.step_mask = `SQSEG_STEP_16 - 32'd1;
      end
      else
      begin
        lim.minimum = `SQSEG_MIN_32;
        lim.step_mask = `SQSEG_STEP_8 - 32'd1;
      end
      unique case (active_channels)
        7'd1: lim.div_shift = 6'd0;
        7'd2: lim.div_shift = 6'd1;
        7'd4: lim.div_shift = 6'd2;
        default: lim.chan_ok = 1'b0;
      endcase
    end
  end

  // Log2 of the programmed count; count is always a power of two
  always_comb
  begin
    count_log2 = 6'd0;
    for (int i = 0; i < 32; i++)
    begin
      if (count_q[i])
      begin
        count_log2 = 6'(i);
      end
    end
  end

  // Memory is a power of two too, so the divides are shifts
  assign max_len = (MEM_SAMPLES >> lim.div_shift) >> count_log2;

  // Power of two, nonzero, and within capability
  assign count_ok = (bus.wdata != 32'h00000000) &&
                    ((bus.wdata & (bus.wdata - 32'd1)) == 32'h00000000) &&
                    (bus.wdata <= SEG_CAP);

  // Zero length means an empty segment, which is legal
  assign len_bad = (mem_rdata != 32'h00000000) &&
                   ((mem_rdata < lim.minimum) ||
                    ((mem_rdata & lim.step_mask) != 32'h00000000) ||
                    ({1'b0, mem_rdata} > max_len));

  assign len_wr = bus.wr && (bus.addr == `SQSEG_IDX_LENGTH) && (st_q != SQSEG_WIPE);

  // Memory read: bus read of the selected segment, else the checker scan
  always_comb
  begin
    if (bus.rd && (bus.addr == `SQSEG_IDX_LENGTH))
    begin
      mem_raddr = sel_q[SEG_LOG2-1:0];
    end
    else
    begin
      mem_raddr = scan_q;
    end
  end

  sqseg_len_mem #(
    .DEPTH_LOG2(SEG_LOG2)
  ) u_len_mem (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(len_wr),
    .wr_addr(sel_q[SEG_LOG2-1:0]),
    .wr_data(bus.wdata),
    .clr_en(st_q == SQSEG_WIPE),
    .clr_addr(wipe_q),
    .rd_addr(mem_raddr),
    .byp_en(bus.rd && (bus.addr != `SQSEG_IDX_LENGTH)),
    .byp_data(rdata_d),
    .rd_data(mem_rdata)
  );

  assign status_word = {28'h0000000, st_q == SQSEG_WIPE, lim.chan_ok,
                        st_q == SQSEG_RUN, err_q};

  // Register writes, wipe sequencing and run control
  always_comb
  begin
    st_d = st_q;
    mode_d = mode_q;
    count_d = count_q;
    sel_d = sel_q;
    wipe_d = wipe_q;
    unique case (st_q)
      SQSEG_IDLE, SQSEG_RUN:
      begin
        if (bus.wr && (bus.addr == `SQSEG_IDX_MODE))
        begin
          mode_d = bus.wdata;
          if (bus.wdata != `SQSEG_SEQ_CODE)
          begin
            st_d = SQSEG_IDLE;
          end
        end
        if (bus.wr && (bus.addr == `SQSEG_IDX_COUNT) && count_ok)
        begin
          count_d = bus.wdata;
          sel_d = `SQSEG_SELECT_RST;
          wipe_d = '0;
          st_d = SQSEG_WIPE;
        end
        if (bus.wr && (bus.addr == `SQSEG_IDX_SELECT) && (bus.wdata < count_q))
        begin
          sel_d = bus.wdata;
        end
        // Start only from a clean full scan
        if (bus.wr && (bus.addr == `SQSEG_IDX_START) && (st_q == SQSEG_IDLE))
        begin
          if ((mode_q == `SQSEG_SEQ_CODE) && !err_q && scan_done_q && lim.chan_ok)
          begin
            st_d = SQSEG_RUN;
          end
        end
        if (bus.wr && (bus.addr == `SQSEG_IDX_START) && (bus.wdata == 32'h00000000))
        begin
          st_d = SQSEG_IDLE;
        end
      end
      SQSEG_WIPE:
      begin
        wipe_d = wipe_q + 1'b1;
        if (wipe_q == {SEG_LOG2{1'b1}})
        begin
          st_d = SQSEG_IDLE;
        end
        // Mode stays writable while the lengths are cleared
        if (bus.wr && (bus.addr == `SQSEG_IDX_MODE))
        begin
          mode_d = bus.wdata;
        end
        // A further count write restarts the wipe from the first segment
        if (bus.wr && (bus.addr == `SQSEG_IDX_COUNT) && count_ok)
        begin
          count_d = bus.wdata;
          sel_d = `SQSEG_SELECT_RST;
          wipe_d = '0;
          st_d = SQSEG_WIPE;
        end
      end
      default: st_d = SQSEG_IDLE;
    endcase
  end

  // Background scan over segments in use; a word arrives a cycle after its address,
  // so pend and last travel with it and the verdict waits for the last segment's word
  always_comb
  begin
    scan_d = scan_q;
    scan_bad_d = scan_bad_q;
    scan_done_d = scan_done_q;
    scan_pend_d = 1'b0;
    scan_last_d = 1'b0;
    err_d = err_q;
    if ((st_q == SQSEG_WIPE) || len_wr)
    begin
      scan_d = '0;
      scan_bad_d = 1'b0;
      scan_done_d = 1'b0;
    end
    else
    begin
      // A bus read owns the read stage this cycle, so the scan address waits
      if (!bus.rd)
      begin
        scan_pend_d = 1'b1;
        if ({{(32-SEG_LOG2){1'b0}}, scan_q} >= count_q - 32'd1)
        begin
          scan_d = '0;
          scan_last_d = 1'b1;
        end
        else
        begin
          scan_d = scan_q + 1'b1;
        end
      end
      if (scan_pend_q && scan_last_q)
      begin
        err_d = scan_bad_q | len_bad | !lim.chan_ok;
        scan_done_d = 1'b1;
        scan_bad_d = 1'b0;
      end
      else if (scan_pend_q)
      begin
        scan_bad_d = scan_bad_q | len_bad;
      end
    end
  end

  // Read multiplexer; the word is registered in the memory's read stage
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (bus.rd)
    begin
      unique case (bus.addr)
        `SQSEG_IDX_MODE: rdata_d = mode_q;
        `SQSEG_IDX_CAP: rdata_d = SEG_CAP;
        `SQSEG_IDX_COUNT: rdata_d = count_q;
        `SQSEG_IDX_SELECT: rdata_d = sel_q;
        `SQSEG_IDX_LENGTH: rdata_d = 32'h00000000;
        `SQSEG_IDX_STATUS: rdata_d = status_word;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data leave the memory's read flop directly
  assign reg_rdata = mem_rdata;

  // State registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_q <= SQSEG_WIPE;
      mode_q <= `SQSEG_MODE_RST;
      count_q <= `SQSEG_COUNT_RST;
      sel_q <= `SQSEG_SELECT_RST;
      wipe_q <= '0;
      scan_q <= '0;
      scan_bad_q <= 1'b0;
      scan_done_q <= 1'b0;
      err_q <= 1'b0;
      scan_pend_q <= 1'b0;
      scan_last_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      mode_q <= mode_d;
      count_q <= count_d;
      sel_q <= sel_d;
      wipe_q <= wipe_d;
      scan_q <= scan_d;
      scan_bad_q <= scan_bad_d;
      scan_done_q <= scan_done_d;
      err_q <= err_d;
      scan_pend_q <= scan_pend_d;
      scan_last_q <= scan_last_d;
    end
  end

  // Registered status outputs
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      replay_run <= 1'b0;
      seq_mode <= 1'b0;
      segment_count_out <= `SQSEG_COUNT_RST;
      cfg_error <= 1'b0;
    end
    else
    begin
      replay_run <= (st_q == SQSEG_RUN);
      seq_mode <= (mode_q == `SQSEG_SEQ_CODE);
      segment_count_out <= count_q;
      cfg_error <= err_q;
    end
  end
endmodule
`default_nettype wire

// [verif/sqseg_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sqseg_consts.svh"
// Port-level checks of the segment setup block
module sqseg_chk
#(
  parameter int SEG_LOG2 = 10
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Channels and replay control
  input wire logic [6:0] active_channels,
  input wire logic replay_run,
  input wire logic seq_mode,
  input wire logic [31:0] segment_count_out,
  input wire logic cfg_error
);
  localparam logic [31:0] CAP = 32'h1 << SEG_LOG2;
  logic cnt_ok;
  // A count write the block has to take
  assign cnt_ok = reg_wr && (reg_addr == `SQSEG_IDX_COUNT) && $onehot(reg_wdata)
    && (reg_wdata <= CAP);
  logic cnt_wr;
  // Any count write, taken or refused
  assign cnt_wr = reg_wr && (reg_addr == `SQSEG_IDX_COUNT);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Mode flag follows the written code
  a_mode_flag: assert property (reg_wr && reg_addr == `SQSEG_IDX_MODE |-> ##2
    seq_mode == ($past(reg_wdata, 2) == `SQSEG_SEQ_CODE)) else $error("mode flag wrong");
  a_run_mode: assert property (replay_run |-> seq_mode)
    else $error("run outside mode");
  // Count is always a legal power of two
  a_count_onehot: assert property ($onehot(segment_count_out))
    else $error("count not power of two");
  a_count_bound: assert property (segment_count_out <= CAP)
    else $error("count above capability");
  a_count_take: assert property (cnt_ok |-> ##2
    segment_count_out == $past(reg_wdata, 2)) else $error("count write lost");
  a_count_hold: assert property (!cnt_wr && !$past(cnt_wr)
    |=> $stable(segment_count_out)) else $error("count moved without write");
  a_count_stop: assert property (cnt_ok |-> ##2 !replay_run)
    else $error("count write left replay running");
  // Read slots of count and capability
  a_count_read: assert property (reg_rd && reg_addr == `SQSEG_IDX_COUNT
    |=> reg_rdata == segment_count_out) else $error("count read wrong");
  a_cap_read: assert property (reg_rd && reg_addr == `SQSEG_IDX_CAP
    |=> reg_rdata == CAP) else $error("capability read wrong");
  a_run_clean: assert property ($rose(replay_run) |-> !cfg_error)
    else $error("replay started with error");
  c_run: cover property ($rose(replay_run));
  c_err: cover property ($rose(cfg_error));
  c_cnt: cover property (cnt_ok);
endmodule
bind sqseg_top sqseg_chk #(.SEG_LOG2(SEG_LOG2)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .active_channels(active_channels), .replay_run(replay_run),
  .seq_mode(seq_mode), .segment_count_out(segment_count_out), .cfg_error(cfg_error));
`default_nettype wire

// [verif/sqseg_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sqseg_consts.svh"
// Host software model driving the register port
module sqseg_host
#(
  parameter int SEG_LOG2 = 3
)
(
  // Clock
  input wire logic mclk,
  // Register port
  output logic [31:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Idle bus at time zero
  initial
  begin
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One strobe cycle; released address and data show inverted values, not stale ones
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  // New count wipes setup, so wait out the wipe before rewriting
  task automatic set_cnt(input logic [31:0] c);
    op(`SQSEG_IDX_COUNT, c, 1'b1);
    repeat ((1 << SEG_LOG2) + 2) @(posedge mclk);
  endtask
  // Select always goes first so the intended segment is updated
  task automatic set_len(input logic [31:0] s, input logic [31:0] n);
    op(`SQSEG_IDX_SELECT, s, 1'b1);
    op(`SQSEG_IDX_LENGTH, n, 1'b1);
  endtask
endmodule
`default_nettype wire

// [verif/sqseg_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sqseg_consts.svh"
module sqseg_top_test;
  localparam logic [31:0] MEM = 32'h02000000;
  logic mclk;
  logic sys_rst;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, segment_count_out;
  logic reg_wr, reg_rd, replay_run, seq_mode, cfg_error;
  logic rd_q = 1'b0;
  logic [6:0] active_channels, ch;
  logic [31:0] c, mx, ln;
  logic [63:0] e;
  logic [63:0] expq[$];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  sqseg_host #(.SEG_LOG2(3)) u_host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  sqseg_top #(.SEG_LOG2(3)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_channels(active_channels), .replay_run(replay_run), .seq_mode(seq_mode),
    .segment_count_out(segment_count_out), .cfg_error(cfg_error));
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (ex & m))
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, ex);
    end
  endtask
  // Note the expected data, then issue the read
  task automatic rdx(input logic [31:0] a, input logic [31:0] ex);
    expq.push_back({32'hFFFFFFFF, ex});
    u_host.op(a, 32'h0, 1'b0);
  endtask
  // Status: only the four defined bits are compared
  task automatic st(input logic er, input logic run, input logic cok);
    expq.push_back({32'h0000000F, 28'h0, 1'b0, cok, run, er});
    u_host.op(`SQSEG_IDX_STATUS, 32'h0, 1'b0);
  endtask
  // Reference limit check: empty is fine, else min, step and max
  function automatic logic exp_err(input logic [31:0] n, input logic [6:0] h,
    input logic [31:0] k);
    logic [31:0] m;
    m = MEM / {25'h0, h} / k;
    return n != 0 && (n < 32 || n % 8 != 0 || n > m);
  endfunction
  // Read data stand only in the cycle after the strobe; also the hang limit
  always @(posedge mclk)
  begin
    if (rd_q && expq.size() > 0)
    begin
      e = expq.pop_front();
      chk(reg_rdata, e[31:0], e[63:32]);
    end
    else if (rd_q)
    begin
      errors++;
      $display("BAD %0t read with no expectation", $time);
    end
    rd_q <= reg_rd;
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    active_channels = 7'h01;
    c = $urandom(32'hEAEB);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rdx(`SQSEG_IDX_CAP, 32'h8);
    rdx(`SQSEG_IDX_COUNT, 32'h1);
    rdx(32'h00000005, 32'h0);
    repeat (10) @(posedge mclk);
    // Mode code and refused counts
    u_host.op(`SQSEG_IDX_MODE, `SQSEG_SEQ_CODE, 1'b1);
    rdx(`SQSEG_IDX_MODE, `SQSEG_SEQ_CODE);
    chk({31'h0, seq_mode}, 32'h1, 32'h1);
    u_host.op(`SQSEG_IDX_COUNT, 32'h3, 1'b1);
    u_host.op(`SQSEG_IDX_COUNT, 32'h10, 1'b1);
    rdx(`SQSEG_IDX_COUNT, 32'h1);
    // Lengths land in the selected segment only
    u_host.set_cnt(32'h4);
    u_host.set_len(32'h2, 32'h40);
    u_host.set_len(32'h1, 32'h28);
    u_host.op(`SQSEG_IDX_SELECT, 32'h5, 1'b1);
    rdx(`SQSEG_IDX_SELECT, 32'h1);
    rdx(`SQSEG_IDX_LENGTH, 32'h28);
    u_host.op(`SQSEG_IDX_SELECT, 32'h2, 1'b1);
    rdx(`SQSEG_IDX_LENGTH, 32'h40);
    u_host.set_cnt(32'h4);
    rdx(`SQSEG_IDX_SELECT, 32'h0);
    u_host.op(`SQSEG_IDX_SELECT, 32'h2, 1'b1);
    rdx(`SQSEG_IDX_LENGTH, 32'h0);
    chk(segment_count_out, 32'h4, 32'hFFFFFFFF);
    // Start is refused while a length is bad
    u_host.set_len(32'h0, 32'h1C);
    repeat (10) @(posedge mclk);
    u_host.op(`SQSEG_IDX_START, 32'h1, 1'b1);
    st(1'b1, 1'b0, 1'b1);
    chk({31'h0, cfg_error}, 32'h1, 32'h1);
    u_host.set_len(32'h0, 32'h20);
    repeat (10) @(posedge mclk);
    u_host.op(`SQSEG_IDX_START, 32'h1, 1'b1);
    st(1'b0, 1'b1, 1'b1);
    chk({31'h0, replay_run}, 32'h1, 32'h1);
    // Start zero stops, a new start runs again
    u_host.op(`SQSEG_IDX_START, 32'h0, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    u_host.op(`SQSEG_IDX_START, 32'h1, 1'b1);
    st(1'b0, 1'b1, 1'b1);
    // Count write while replaying stops it and wipes the lengths
    u_host.set_cnt(32'h4);
    st(1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    u_host.op(`SQSEG_IDX_START, 32'h1, 1'b1);
    st(1'b0, 1'b1, 1'b1);
    u_host.op(`SQSEG_IDX_MODE, 32'h0, 1'b1);
    st(1'b0, 1'b0, 1'b1);
    active_channels <= 7'h03;
    repeat (12) @(posedge mclk);
    st(1'b1, 1'b0, 1'b0);
    chk({31'h0, cfg_error}, 32'h1, 32'h1);
    // Random counts, channels and lengths around the limits
    for (int i = 0; i < 30; i++)
    begin
      c = 32'h1 << ($urandom % 4);
      ch = 7'h01 << ($urandom % 3);
      mx = MEM / {25'h0, ch} / c;
      case ($urandom % 3)
        0: ln = $urandom % 80;
        1: ln = mx + ($urandom % 3) * 8 - 8;
        default: ln = ($urandom % (mx / 8)) * 8;
      endcase
      active_channels <= ch;
      u_host.set_cnt(c);
      u_host.set_len($urandom % c, ln);
      repeat (12) @(posedge mclk);
      st(exp_err(ln, ch, c), 1'b0, 1'b1);
      chk({31'h0, cfg_error}, {31'h0, exp_err(ln, ch, c)}, 32'h1);
    end
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule
`default_nettype wire
